// ==== dmp_top.v ====
// Discrete monitor port: address decode, command bits, monitor readout
// Behaviour
// - Act only on messages carrying own address
// - Acknowledges carry own strapped unit address
// - Address inputs form binary code, bit5 most significant
// - Generator modules drive no command outputs
// - Cubicle: start bit zero closes start relay
// - Monitor bits pass uninverted beyond isolator
// - Applied 24 volts reads low, zero reads high
// - Cubicle bits 2,3 breakers; 4-7,14 unused
// - Sixteen bits: two commands low, fourteen monitors
`timescale 1ns/100ps
module dmp_top (
    // Clock and reset
    input wire clock_i,
    input wire rst_i,
    // Unit address strap pins
    input wire [5:0] strap_i,
    // Isolated monitor inputs, port bits 15..2
    input wire [13:0] monitor_i,
    // Bus request message
    input wire req_valid_i,
    input wire [5:0] req_addr_i,
    input wire req_is_cmd_i,
    input wire [15:0] req_data_i,
    // Acknowledge message
    output reg ack_valid_o,
    output reg [5:0] ack_addr_o,
    output reg ack_is_cmd_o,
    output reg [15:0] ack_data_o,
    // Relay drives, high closes the normally open contact
    output reg start_relay_o,
    output reg second_relay_o,
    // Register port
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    // Interrupt
    output wire irq_o
);
`include "dmp_defines.vh"

    // ======================================================================
    // Declarations
    // ======================================================================
    reg [1:0] cmd_reg;
    reg [1:0] cmd_next;
    reg role_reg;
    reg [13:0] mon_prev_reg;
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_en_reg;
    reg [3:0] evt_next;
    reg [5:0] last_req_reg;
    wire [5:0] unit_addr;
    wire hit;
    wire req_take;
    wire [15:0] port_word;
    wire [15:0] port_cmd_word;

    // Decodes a register index against a given register offset
    function sel;
        input [3:0] addr;
        input [3:0] which;
        begin
            sel = (addr == which);
        end
    endfunction

    // ======================================================================
    // Address decode
    // ======================================================================
    dmp_addr_match u_match (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .strap_i(strap_i),
        .req_addr_i(req_addr_i),
        .unit_addr_o(unit_addr),
        .hit_o(hit)
    );

    // Foreign messages are not taken; only the foreign event and request trace see them
    assign req_take = req_valid_i && hit;

    // ======================================================================
    // Port word
    // ======================================================================
    // Monitors pass straight through; isolator already inverted them
    assign port_word = {monitor_i, cmd_reg};
    // Command reply reflects the bits just being written
    assign port_cmd_word = {monitor_i, cmd_next};

    // ======================================================================
    // Command bits
    // ======================================================================
    // Message write wins over a software write in the same cycle
    always @* begin
        cmd_next = cmd_reg;
        if (reg_wr_i && sel(reg_addr_i, `DMP_REG_CMD)) begin
            cmd_next = reg_wdata_i[1:0];
        end
        if (req_take && req_is_cmd_i) begin
            cmd_next = req_data_i[1:0];
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            cmd_reg <= `DMP_CMD_RST;
        end else begin
            cmd_reg <= cmd_next;
        end
    end

    // ======================================================================
    // Relay drives
    // ======================================================================
    // Only the cubicle role closes a contact, and only for the start bit
    always @(posedge clock_i) begin
        if (rst_i) begin
            start_relay_o <= 1'b0;
            second_relay_o <= 1'b0;
        end else begin
            // Zero in the start bit closes the contact
            start_relay_o <= (role_reg == `DMP_ROLE_CUBICLE) &&
                             !cmd_reg[`DMP_START_BIT];
            // Second bit is wired to nothing in either role
            second_relay_o <= 1'b0;
        end
    end

    // ======================================================================
    // Acknowledge
    // ======================================================================
    // One-cycle reply after each own request, address always inserted
    always @(posedge clock_i) begin
        if (rst_i) begin
            ack_valid_o <= 1'b0;
            ack_addr_o <= 6'h00;
            ack_is_cmd_o <= 1'b0;
            ack_data_o <= 16'h0000;
        end else begin
            ack_valid_o <= req_take;
            if (req_take) begin
                ack_addr_o <= unit_addr;
                ack_is_cmd_o <= req_is_cmd_i;
                if (req_is_cmd_i) begin
                    ack_data_o <= port_cmd_word;
                end else begin
                    ack_data_o <= port_word;
                end
            end
        end
    end

    // ======================================================================
    // Role and request trace
    // ======================================================================
    always @(posedge clock_i) begin
        if (rst_i) begin
            role_reg <= `DMP_ROLE_RST;
            last_req_reg <= 6'h00;
        end else begin
            if (reg_wr_i && sel(reg_addr_i, `DMP_REG_ROLE)) begin
                role_reg <= reg_wdata_i[0];
            end
            if (req_valid_i) begin
                last_req_reg <= req_addr_i;
            end
        end
    end

    // ======================================================================
    // Events and interrupt
    // ======================================================================
    // Monitor change compares against last sample; inputs are synchronous
    always @* begin
        evt_next = `DMP_EVT_RST;
        evt_next[`DMP_EVT_MATCH] = req_take;
        evt_next[`DMP_EVT_FOREIGN] = req_valid_i && !hit;
        evt_next[`DMP_EVT_MON_CHG] = (monitor_i != mon_prev_reg);
        evt_next[`DMP_EVT_CMD_CHG] = (cmd_next != cmd_reg);
    end

    // Set beats clear so an event in the clear cycle survives
    always @(posedge clock_i) begin
        if (rst_i) begin
            irq_stat_reg <= `DMP_EVT_RST;
            irq_en_reg <= `DMP_EVT_RST;
            mon_prev_reg <= 14'h3FFF;
        end else begin
            mon_prev_reg <= monitor_i;
            if (reg_wr_i && sel(reg_addr_i, `DMP_REG_IRQ_CLR)) begin
                irq_stat_reg <= (irq_stat_reg & ~reg_wdata_i[3:0]) |
                                evt_next;
            end else begin
                irq_stat_reg <= irq_stat_reg | evt_next;
            end
            if (reg_wr_i && sel(reg_addr_i, `DMP_REG_IRQ_EN)) begin
                irq_en_reg <= reg_wdata_i[3:0];
            end
        end
    end

    assign irq_o = |(irq_stat_reg & irq_en_reg);

    // ======================================================================
    // Register read
    // ======================================================================
    // Data stands only in the cycle after the read strobe
    always @(posedge clock_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DMP_REG_PORT: reg_rdata_o <= {16'h0000, port_word};
                `DMP_REG_CMD: reg_rdata_o <= {30'h00000000, cmd_reg};
                `DMP_REG_ROLE: reg_rdata_o <= {31'h00000000, role_reg};
                `DMP_REG_UNIT: reg_rdata_o <= {26'h0000000, unit_addr};
                `DMP_REG_IRQ_STAT: reg_rdata_o <= {28'h0000000, irq_stat_reg};
                `DMP_REG_IRQ_EN: reg_rdata_o <= {28'h0000000, irq_en_reg};
                `DMP_REG_LAST_REQ: reg_rdata_o <= {26'h0000000, last_req_reg};
                default: reg_rdata_o <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

endmodule // dmp_top

// ==== dmp_defines.vh ====
// Constants for the discrete monitor port: offsets, fields, resets, codes
`ifndef DMP_DEFINES_VH
`define DMP_DEFINES_VH

// ==========================================================================
// Port word layout
// ==========================================================================
`define DMP_PORT_W 16
`define DMP_CMD_W 2
`define DMP_MON_W 14
`define DMP_MON_LSB 2
`define DMP_START_BIT 0
`define DMP_SECOND_BIT 1
`define DMP_CUB_TIE_BRK_BIT 2
`define DMP_CUB_UTIL_BRK_BIT 3
`define DMP_CUB_AC_CTRL_BIT 8
`define DMP_CUB_FUEL1_BIT 9
`define DMP_CUB_FUEL2_BIT 10
`define DMP_CUB_VF_FAIL_BIT 11
`define DMP_CUB_LOAD_SHED_BIT 12
`define DMP_CUB_HORN_BIT 13
`define DMP_CUB_UNUSED_MASK 16'h40F0

// ==========================================================================
// Unit address
// ==========================================================================
`define DMP_ADDR_W 6
`define DMP_ADDR_FIXED_BIT 5
`define DMP_ADDR_GEN1 6'h02
`define DMP_ADDR_GEN2 6'h03
`define DMP_ADDR_CUBICLE 6'h04

// ==========================================================================
// Register offsets (word index on the register port)
// ==========================================================================
`define DMP_RA_W 4
`define DMP_REG_PORT 4'h0
`define DMP_REG_CMD 4'h1
`define DMP_REG_ROLE 4'h2
`define DMP_REG_UNIT 4'h3
`define DMP_REG_IRQ_STAT 4'h4
`define DMP_REG_IRQ_CLR 4'h5
`define DMP_REG_IRQ_EN 4'h6
`define DMP_REG_LAST_REQ 4'h7

// ==========================================================================
// Reset values and codes
// ==========================================================================
`define DMP_CMD_RST 2'h3
`define DMP_ROLE_GENERATOR 1'h0
`define DMP_ROLE_CUBICLE 1'h1
`define DMP_ROLE_RST 1'h0
`define DMP_EVT_W 4
`define DMP_EVT_RST 4'h0
`define DMP_EVT_MATCH 0
`define DMP_EVT_FOREIGN 1
`define DMP_EVT_MON_CHG 2
`define DMP_EVT_CMD_CHG 3

`endif

// ==== dmp_addr_match.v ====
// Strapped unit address capture and request address comparison
`timescale 1ns/100ps
module dmp_addr_match (
    // Clock and reset
    input wire clock_i,
    input wire rst_i,
    // Strap pins and request address
    input wire [5:0] strap_i,
    input wire [5:0] req_addr_i,
    // Results
    output reg [5:0] unit_addr_o,
    output wire hit_o
);
`include "dmp_defines.vh"

    reg captured_reg;

    // ======================================================================
    // Strap capture
    // ======================================================================
    // Straps are caught once after reset release; they never move in use
    always @(posedge clock_i) begin
        if (rst_i) begin
            captured_reg <= 1'b0;
            unit_addr_o <= 6'h00;
        end else if (!captured_reg) begin
            captured_reg <= 1'b1;
            // Open pin reads 1, grounded reads 0: value taken as binary
            unit_addr_o <= strap_i;
        end
    end

    // ======================================================================
    // Compare
    // ======================================================================
    // No hit before straps are held, so early requests are ignored
    assign hit_o = captured_reg && (req_addr_i == unit_addr_o);

endmodule // dmp_addr_match

// ==== dmp_chk_monitor.sv ====
// Checker for acknowledge, relay and register-read timing
`timescale 1ns/100ps
`include "dmp_defines.vh"
module dmp_chk (
    // Clock and reset
    input wire clock_i,
    input wire rst_i,
    // Watched inputs
    input wire [5:0] strap_i,
    input wire [13:0] monitor_i,
    input wire req_valid_i,
    input wire [5:0] req_addr_i,
    input wire req_is_cmd_i,
    input wire [15:0] req_data_i,
    input wire [3:0] reg_addr_i,
    input wire reg_rd_i,
    // Watched outputs
    input wire ack_valid_o,
    input wire [5:0] ack_addr_o,
    input wire ack_is_cmd_o,
    input wire [15:0] ack_data_o,
    input wire start_relay_o,
    input wire [31:0] reg_rdata_o,
    input wire irq_o
);
    reg live_reg;
    wire own;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // ========================================================
    // Straps land one edge after reset, so no match before
    always @(posedge clock_i) begin
        live_reg <= !rst_i;
    end
    assign own = live_reg && req_valid_i && req_addr_i == strap_i;
    own_ack_a:
        assert property (own |=> ack_valid_o && ack_addr_o == strap_i)
        else $error("own request not acknowledged");
    foreign_quiet_a:
        assert property (!own |=> !ack_valid_o)
        else $error("acknowledge without own request");
    ack_kind_a:
        assert property (ack_valid_o |-> ack_is_cmd_o == $past(req_is_cmd_i))
        else $error("acknowledge kind wrong");
    mon_echo_a:
        assert property (ack_valid_o && !ack_is_cmd_o
            |-> ack_data_o[15:2] == $past(monitor_i))
        else $error("monitor word wrong");
    cmd_echo_a:
        assert property (ack_valid_o && ack_is_cmd_o
            |-> ack_data_o == {$past(monitor_i), $past(req_data_i[1:0])})
        else $error("command echo wrong");
    relay_open_a:
        assert property (ack_valid_o && ack_is_cmd_o && ack_data_o[0]
            |=> !start_relay_o)
        else $error("start relay closed on inactive command");
    rdata_idle_a:
        assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside read slot");
    port_read_a:
        assert property (reg_rd_i && reg_addr_i == `DMP_REG_PORT
            |=> reg_rdata_o[31:2] == {16'h0, $past(monitor_i)})
        else $error("port word read wrong");
    cover property (own && req_is_cmd_i);
    cover property ($rose(start_relay_o));
    cover property (irq_o);
endmodule // dmp_chk

// ==== dmp_pc_model.sv ====
// Control computer model: polls the port, captures acknowledges
`timescale 1ns/100ps
module dmp_pc_model (
    // Clock
    input wire clock_i,
    // Request message
    output reg req_valid_o,
    output reg [5:0] req_addr_o,
    output reg req_is_cmd_o,
    output reg [15:0] req_data_o,
    // Acknowledge message
    input wire ack_valid_i,
    input wire [5:0] ack_addr_i,
    input wire ack_is_cmd_i,
    input wire [15:0] ack_data_i
);
    reg got_ack;
    reg [5:0] got_addr;
    reg [15:0] got_data;
    initial begin
        req_valid_o = 1'b0;
        req_addr_o = 6'h3F;
        req_is_cmd_o = 1'b0;
        req_data_o = 16'hFFFF;
    end
    // One request after gap idle cycles; answer due one edge later
    task send(input [5:0] a, input k, input [15:0] d, input integer gap);
        begin
            repeat (gap) @(posedge clock_i);
            @(posedge clock_i);
            req_valid_o <= 1'b1;
            req_addr_o <= a;
            req_is_cmd_o <= k;
            req_data_o <= d;
            @(posedge clock_i);
            // Released lines show the inverse, never a stale copy
            req_valid_o <= 1'b0;
            req_addr_o <= ~a;
            req_is_cmd_o <= ~k;
            req_data_o <= ~d;
            #1;
            got_ack = ack_valid_i;
            got_addr = ack_addr_i;
            got_data = ack_data_i;
        end
    endtask
endmodule // dmp_pc_model

// ==== dmp_top_tb_top.sv ====
// Self-checking testbench for the discrete monitor port
`timescale 1ns/100ps
`include "dmp_defines.vh"
module dmp_top_tb_top;
    reg clock_i, rst_i, reg_wr_i, reg_rd_i, cub;
    reg [5:0] strap_i, code;
    reg [13:0] monitor_i, mon;
    reg [3:0] reg_addr_i;
    reg [31:0] reg_wdata_i, d;
    reg [1:0] cmd;
    wire req_valid_i, req_is_cmd_i, ack_valid_o, ack_is_cmd_o, irq_o;
    wire start_relay_o, second_relay_o;
    wire [5:0] req_addr_i, ack_addr_o;
    wire [15:0] req_data_i, ack_data_o;
    wire [31:0] reg_rdata_o;
    integer failures, checked, i, k;
    dmp_top dut (.clock_i(clock_i), .rst_i(rst_i), .strap_i(strap_i),
        .monitor_i(monitor_i), .req_valid_i(req_valid_i),
        .req_addr_i(req_addr_i), .req_is_cmd_i(req_is_cmd_i),
        .req_data_i(req_data_i), .ack_valid_o(ack_valid_o),
        .ack_addr_o(ack_addr_o), .ack_is_cmd_o(ack_is_cmd_o),
        .ack_data_o(ack_data_o), .start_relay_o(start_relay_o),
        .second_relay_o(second_relay_o), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
    dmp_pc_model pc (.clock_i(clock_i), .req_valid_o(req_valid_i),
        .req_addr_o(req_addr_i), .req_is_cmd_o(req_is_cmd_i),
        .req_data_o(req_data_i), .ack_valid_i(ack_valid_o),
        .ack_addr_i(ack_addr_o), .ack_is_cmd_i(ack_is_cmd_o),
        .ack_data_i(ack_data_o));
    // ========================================================
    // Clock, 25 ns period
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    function [31:0] exp_port(input [13:0] m, input [1:0] c);
        exp_port = {16'h0, m, c};
    endfunction
    // Only a cubicle unit closes the start contact, on a zero
    function exp_relay(input r, input [1:0] c);
        exp_relay = r & ~c[0];
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[ERR] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task reg_write(input [3:0] a, input [31:0] v);
        begin
            @(posedge clock_i);
            reg_addr_i <= a;
            reg_wdata_i <= v;
            reg_wr_i <= 1'b1;
            @(posedge clock_i);
            reg_wr_i <= 1'b0;
            #1;
        end
    endtask
    task reg_read(input [3:0] a, output [31:0] v);
        begin
            @(posedge clock_i);
            reg_addr_i <= a;
            reg_rd_i <= 1'b1;
            @(posedge clock_i);
            reg_rd_i <= 1'b0;
            #1;
            v = reg_rdata_o;
        end
    endtask
    task give_verdict;
        begin
            $display("failures=%0d checked=%0d", failures, checked);
            if (failures == 0 && checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clock_i);
        failures = failures + 1;
        give_verdict;
    end
    // ========================================================
    // Main sequence: one pass per strapped unit address
    initial begin
        failures = 0;
        checked = 0;
        {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 39'h4000000000;
        strap_i = 6'h3F;
        monitor_i = 14'h3FFF;
        d = $urandom(10);
        for (i = 0; i < 4; i = i + 1) begin
            // Generators 2, 3, cubicle 4, then a spare code; bit 5 grounded
            code = (i < 3) ? 6'h02 + i[5:0] : {2'h0, d[3:0]} + 6'h05;
            cub = (code == `DMP_ADDR_CUBICLE);
            @(posedge clock_i);
            rst_i <= 1'b1;
            strap_i <= code;
            repeat (4) @(posedge clock_i);
            rst_i <= 1'b0;
            reg_write(`DMP_REG_ROLE, {31'h0, cub});
            reg_read(`DMP_REG_UNIT, d);
            chk(d, {26'h0, code});
            reg_read(4'hC, d);
            chk(d, 32'h0);
            for (k = 0; k < 5; k = k + 1) begin
                mon = $urandom;
                if (k == 0) mon = 14'h0000;
                cmd = (k < 4) ? k[1:0] : 2'h3;
                monitor_i <= mon;
                d = $urandom;
                pc.send(code, 1'b1, {d[13:0], cmd}, k);
                chk({pc.got_data}, exp_port(mon, cmd));
                pc.send(code, 1'b0, d[15:0], 0);
                chk({pc.got_ack, pc.got_addr}, {1'b1, code});
                chk({pc.got_data}, exp_port(mon, cmd));
                chk({start_relay_o, second_relay_o},
                    {exp_relay(cub, cmd), 1'b0});
                reg_read(`DMP_REG_PORT, d);
                chk(d, exp_port(mon, cmd));
            end
            // A foreign start command must leave ack and relay alone but raise status
            reg_write(`DMP_REG_IRQ_EN, 32'h2);
            pc.send(code ^ 6'h01, 1'b1, 16'h0000, 0);
            chk({pc.got_ack, start_relay_o, irq_o}, 3'h1);
            // Trace register records any address seen, foreign ones too
            reg_read(`DMP_REG_LAST_REQ, d);
            chk(d, {26'h0, code ^ 6'h01});
            reg_write(`DMP_REG_IRQ_EN, 32'h0);
            chk(irq_o, 1'b0);
            reg_write(`DMP_REG_IRQ_CLR, 32'h2);
            reg_write(`DMP_REG_IRQ_EN, 32'h2);
            chk(irq_o, 1'b0);
        end
        give_verdict;
    end
endmodule // dmp_top_tb_top

// Attach the checker to every port instance
bind dmp_top dmp_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .strap_i(strap_i), .monitor_i(monitor_i), .req_valid_i(req_valid_i),
    .req_addr_i(req_addr_i), .req_is_cmd_i(req_is_cmd_i),
    .req_data_i(req_data_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
    .ack_valid_o(ack_valid_o), .ack_addr_o(ack_addr_o),
    .ack_is_cmd_o(ack_is_cmd_o), .ack_data_o(ack_data_o),
    .start_relay_o(start_relay_o), .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o));
